// file: hdl/sfr_write_guard.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
module sfr_write_guard
  import sfr_guard_pkg::*;
#(
  parameter int         PINS        = 8,
  parameter logic [7:0] INPUT_ONLY  = 8'h02,
  parameter logic [7:0] OUTPUT_ONLY = 8'h01
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port pins
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe,
  // Settings seen by other blocks
  output logic      [2:0]  guard_state,
  output logic      [7:0]  clock_select,
  output logic      [7:0]  irq_mask
);
  localparam int NREG = 22;

  if (PINS < 1 || PINS > 8) begin : g_pins_bad
    $error("PINS must be 1 to 8");
  end

  logic [2:0]  guard_r;
  logic [2:0]  guard_nxt;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [7:0]  regv [NREG];
  logic [7:0]  pin_level_r;
  logic [2:0]  guard_q_r;
  logic [7:0]  clock_select_r;
  logic [7:0]  irq_mask_r;

  // Register table: offset, group, reset value per entry
  localparam logic [7:0] OFS [NREG] = '{
    PORT_DIRECTION_OFS, PULLUP_ENABLE_OFS, INPUT_BUFFER_MODE_OFS, OUTPUT_DRIVE_MODE_OFS,
    PIN_MODE_CONTROL_OFS, INPUT_THRESHOLD_OFS, ANALOG_PORT_CONFIG_OFS, PIN_REDIRECTION_OFS,
    IRQ_FLAG_OFS, IRQ_MASK_OFS, IRQ_PRIORITY_OFS, RISING_EDGE_ENABLE_OFS, FALLING_EDGE_ENABLE_OFS,
    OSC_CONTROL_OFS, CLOCK_SELECT_OFS, PERIPH_ENABLE_OFS, PLL_CONTROL_OFS, MAIN_CLOCK_DIVIDER_OFS,
    VOLTAGE_DETECT_MODE_OFS, VOLTAGE_DETECT_LEVEL_OFS, PORT_OUTPUT_LATCH_OFS, ACCESS_GUARD_CONTROL_OFS};
  localparam reg_group_e GRP [NREG] = '{
    GROUP_PORT, GROUP_PORT, GROUP_PORT, GROUP_PORT, GROUP_PORT, GROUP_PORT, GROUP_PORT, GROUP_PORT,
    GROUP_IRQ, GROUP_IRQ, GROUP_IRQ, GROUP_IRQ, GROUP_IRQ,
    GROUP_CLOCK, GROUP_CLOCK, GROUP_CLOCK, GROUP_CLOCK, GROUP_CLOCK, GROUP_CLOCK, GROUP_CLOCK,
    GROUP_NONE, GROUP_NONE};
  localparam logic [7:0] RSTV [NREG] = '{
    PORT_DIRECTION_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET,
    GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, IRQ_MASK_RESET, IRQ_PRIORITY_RESET, GENERIC_RESET,
    GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, MAIN_CLOCK_DIVIDER_RESET,
    GENERIC_RESET, GENERIC_RESET, GENERIC_RESET, GENERIC_RESET};

  // APB decode; every access takes one wait state and completes in its second access cycle
  wire        access   = psel && penable;
  wire        wr_cycle = access && pwrite && !pready_r;
  wire        rd_cycle = access && !pwrite && !pready_r;
  wire        word_ok  = (paddr[1:0] == 2'b00) && (paddr[11:8] == 4'h0);
  wire        guard_hit = word_ok && paddr[7:0] == ACCESS_GUARD_CONTROL_OFS;
  wire        level_hit = word_ok && paddr[7:0] == PORT_PIN_LEVEL_OFS;
  logic [NREG-1:0] hit;
  logic [NREG-1:0] grp_guarded;
  logic [7:0]      rd_mux;

  genvar g;
  for (g = 0; g < NREG - 1; g++) begin : g_reg
    assign hit[g] = word_ok && paddr[7:0] == OFS[g];
    assign grp_guarded[g] =
        (GRP[g] == GROUP_PORT  && guard_r[PORT_GROUP_GUARD_BIT])      ||
        (GRP[g] == GROUP_IRQ   && guard_r[INTERRUPT_GROUP_GUARD_BIT]) ||
        (GRP[g] == GROUP_CLOCK && guard_r[CLOCK_GROUP_GUARD_BIT]);
    guard_reg #(.RESET_VALUE(RSTV[g])) u_reg (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (wr_cycle && hit[g]),
      .guarded (grp_guarded[g]),
      .wr_data (pwdata[7:0]),
      .value   (regv[g])
    );
  end
  assign hit[NREG-1]         = guard_hit;
  assign grp_guarded[NREG-1] = 1'b0;
  assign regv[NREG-1]        = {5'h00, guard_r};

  // Guard bits written independently of each other; reset clears all
  assign guard_nxt = (wr_cycle && guard_hit) ? pwdata[GUARD_BITS-1:0] : guard_r;

  // Read mux ignores guards entirely
  always_comb begin
    rd_mux = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      if (hit[k]) rd_mux = regv[k];
    end
    if (level_hit) rd_mux = pin_level_r;
  end

  wire unmapped = !((|hit) || level_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_r <= ACCESS_GUARD_CONTROL_RESET;
    end else begin
      guard_r <= guard_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access && !pready_r;
      pslverr_r <= access && !pready_r && unmapped;
      prdata_r  <= rd_cycle ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_r    <= 8'h00;
      guard_q_r      <= ACCESS_GUARD_CONTROL_RESET;
      clock_select_r <= GENERIC_RESET;
      irq_mask_r     <= IRQ_MASK_RESET;
    end else begin
      pin_level_r    <= 8'(pad_in);
      guard_q_r      <= guard_r;
      clock_select_r <= regv[14];
      irq_mask_r     <= regv[9];
    end
  end

  port_pad_ctrl #(
    .PINS        (PINS),
    .INPUT_ONLY  (INPUT_ONLY),
    .OUTPUT_ONLY (OUTPUT_ONLY)
  ) u_pads (
    .pclk       (pclk),
    .presetn    (presetn),
    .dir_input  (regv[0][PINS-1:0]),
    .open_drain (regv[3][PINS-1:0]),
    .latch      (regv[20][PINS-1:0]),
    .pad_out    (pad_out),
    .pad_oe     (pad_oe)
  );

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign guard_state  = guard_q_r;
  assign clock_select = clock_select_r;
  assign irq_mask     = irq_mask_r;

  guarded_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && hit[0] && guard_r[PORT_GROUP_GUARD_BIT] |=> $stable(regv[0]))
    else $error("guarded port write changed register");
  irq_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && hit[9] && guard_r[INTERRUPT_GROUP_GUARD_BIT] |=> $stable(regv[9]))
    else $error("guarded irq write changed register");
  clock_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && hit[14] && guard_r[CLOCK_GROUP_GUARD_BIT] |=> $stable(regv[14]))
    else $error("guarded clock write changed register");
  open_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cycle && hit[14] && !guard_r[CLOCK_GROUP_GUARD_BIT] |=> regv[14] == $past(pwdata[7:0]))
    else $error("unguarded write lost");
  guarded_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_cycle && hit[0] |=> prdata[7:0] == $past(regv[0]) && pready)
    else $error("guarded read wrong");
  od_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    regv[3][2] && regv[20][2] && !INPUT_ONLY[2] && !OUTPUT_ONLY[2] |=> !pad_oe[2])
    else $error("open-drain pin drove high");
  guard_reset_a: assert property (@(posedge pclk)
    $rose(presetn) |-> guard_r == 3'h0)
    else $error("guard not clear after reset");
endmodule

// file: hdl/sfr_guard_pkg.sv
package sfr_guard_pkg;
  // Register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] ACCESS_GUARD_CONTROL_OFS    = 8'h00;
  localparam logic [7:0] PORT_DIRECTION_OFS          = 8'h04;
  localparam logic [7:0] PULLUP_ENABLE_OFS           = 8'h08;
  localparam logic [7:0] INPUT_BUFFER_MODE_OFS       = 8'h0C;
  localparam logic [7:0] OUTPUT_DRIVE_MODE_OFS       = 8'h10;
  localparam logic [7:0] PIN_MODE_CONTROL_OFS        = 8'h14;
  localparam logic [7:0] INPUT_THRESHOLD_OFS         = 8'h18;
  localparam logic [7:0] ANALOG_PORT_CONFIG_OFS      = 8'h1C;
  localparam logic [7:0] PIN_REDIRECTION_OFS         = 8'h20;
  localparam logic [7:0] PORT_OUTPUT_LATCH_OFS       = 8'h24;
  localparam logic [7:0] PORT_PIN_LEVEL_OFS          = 8'h28;
  localparam logic [7:0] IRQ_FLAG_OFS                = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFS                = 8'h44;
  localparam logic [7:0] IRQ_PRIORITY_OFS            = 8'h48;
  localparam logic [7:0] RISING_EDGE_ENABLE_OFS      = 8'h4C;
  localparam logic [7:0] FALLING_EDGE_ENABLE_OFS     = 8'h50;
  localparam logic [7:0] OSC_CONTROL_OFS             = 8'h80;
  localparam logic [7:0] CLOCK_SELECT_OFS            = 8'h84;
  localparam logic [7:0] PERIPH_ENABLE_OFS           = 8'h88;
  localparam logic [7:0] PLL_CONTROL_OFS             = 8'h8C;
  localparam logic [7:0] MAIN_CLOCK_DIVIDER_OFS      = 8'h90;
  localparam logic [7:0] VOLTAGE_DETECT_MODE_OFS     = 8'h94;
  localparam logic [7:0] VOLTAGE_DETECT_LEVEL_OFS    = 8'h98;
  // Guard control fields
  localparam int         CLOCK_GROUP_GUARD_BIT       = 0;
  localparam int         INTERRUPT_GROUP_GUARD_BIT   = 1;
  localparam int         PORT_GROUP_GUARD_BIT        = 2;
  localparam int         GUARD_BITS                  = 3;
  localparam logic [2:0] ACCESS_GUARD_CONTROL_RESET  = 3'h0;
  // Register reset values
  localparam logic [7:0] PORT_DIRECTION_RESET        = 8'hFF;
  localparam logic [7:0] IRQ_MASK_RESET              = 8'hFF;
  localparam logic [7:0] IRQ_PRIORITY_RESET          = 8'hFF;
  localparam logic [7:0] MAIN_CLOCK_DIVIDER_RESET    = 8'h01;
  localparam logic [7:0] GENERIC_RESET               = 8'h00;
  // Register group codes
  typedef enum logic [1:0] {
    GROUP_NONE  = 2'b00,
    GROUP_PORT  = 2'b01,
    GROUP_IRQ   = 2'b10,
    GROUP_CLOCK = 2'b11
  } reg_group_e;
endpackage

// file: hdl/guard_reg.sv
// One 8-bit guarded register: write only when the strobe is set and no guard.
module guard_reg
  import sfr_guard_pkg::*;
#(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Write side
  input  wire logic       wr_en,
  input  wire logic       guarded,
  input  wire logic [7:0] wr_data,
  // Contents
  output logic      [7:0] value
);
  logic [7:0] value_r;
  wire        accept = wr_en && !guarded;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= RESET_VALUE;
    end else if (accept) begin
      value_r <= wr_data;
    end
  end

  assign value = value_r;
endmodule

// file: hdl/port_pad_ctrl.sv
// Per-pin pad driver: direction, open-drain and fixed-function pins.
module port_pad_ctrl
  import sfr_guard_pkg::*;
#(
  parameter int         PINS        = 8,
  parameter logic [7:0] INPUT_ONLY  = 8'h00,
  parameter logic [7:0] OUTPUT_ONLY = 8'h00
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Settings
  input  wire logic [PINS-1:0] dir_input,
  input  wire logic [PINS-1:0] open_drain,
  input  wire logic [PINS-1:0] latch,
  // Pad
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe
);
  logic [PINS-1:0] pad_out_r;
  logic [PINS-1:0] pad_oe_r;
  logic [PINS-1:0] oe_nxt;
  logic [PINS-1:0] out_nxt;

  if (PINS < 1 || PINS > 8) begin : g_pins_bad
    $error("PINS must be 1 to 8");
  end
  if ((INPUT_ONLY & OUTPUT_ONLY) != 8'h00) begin : g_pins_clash
    $error("pin both input-only and output-only");
  end

  genvar i;
  for (i = 0; i < PINS; i++) begin : g_pin
    wire drive_wanted = OUTPUT_ONLY[i] || !dir_input[i];
    wire od_release   = open_drain[i] && !OUTPUT_ONLY[i] && latch[i];
    assign oe_nxt[i]  = !INPUT_ONLY[i] && drive_wanted && !od_release;
    assign out_nxt[i] = latch[i] && !od_release;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_r <= '0;
      pad_oe_r  <= '0;
    end else begin
      pad_out_r <= out_nxt;
      pad_oe_r  <= oe_nxt;
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe  = pad_oe_r;

  input_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pad_oe_r & PINS'(INPUT_ONLY)) == '0) else $error("input-only pin driven");
  // Pads load the first register values one edge after release
  output_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> (pad_oe_r & PINS'(OUTPUT_ONLY)) == PINS'(OUTPUT_ONLY))
    else $error("output-only pin released");
endmodule

// file: testbench/sfr_write_guard_tb.sv
module sfr_write_guard_tb
  import sfr_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pad_in;
  logic [7:0]  pad_out;
  logic [7:0]  pad_oe;
  logic [2:0]  guard_state;
  logic [7:0]  clock_select;
  logic [7:0]  irq_mask;
  int          err_total;
  int          n_tests;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  model_mem [0:63];
  logic [7:0]  grp_base [0:2] = '{OSC_CONTROL_OFS, IRQ_FLAG_OFS, PORT_DIRECTION_OFS};
  int          grp_cnt [0:2] = '{7, 5, 8};

  sfr_write_guard #(.PINS(8), .INPUT_ONLY(8'h02), .OUTPUT_ONLY(8'h01)) i_sfr_write_guard (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .guard_state(guard_state),
    .clock_select(clock_select), .irq_mask(irq_mask)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Setup cycle, then access phase held until pready is sampled high
  task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
           output logic [31:0] rdat, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) check(32'h0, 32'h1);
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0, rd, er);
    check(rd, exp);
  endtask

  task test_reset;
    rchk(12'(ACCESS_GUARD_CONTROL_OFS), 32'h0);
    check(32'(guard_state), 32'h0);
    for (int k = 0; k < 3; k++)
      for (int i = 0; i < grp_cnt[k]; i++)
        rchk(12'(grp_base[k]) + 12'(4 * i), 32'(model_mem[grp_base[k][7:2] + i]));
    $display("test_reset done");
  endtask

  // Each pass sets one guard pattern, writes every group register, reads all back
  task test_guard;
    logic [2:0]  g;
    logic [7:0]  d;
    logic [11:0] a;
    for (int p = 0; p < 5; p++) begin
      g = (p == 4) ? 3'h7 : ((p == 0) ? 3'h0 : 3'(1 << (p - 1)));
      apb(1'b1, 12'(ACCESS_GUARD_CONTROL_OFS), 32'(g), rd, er);
      rchk(12'(ACCESS_GUARD_CONTROL_OFS), 32'(g));
      check(32'(guard_state), 32'(g));
      for (int k = 0; k < 3; k++)
        for (int i = 0; i < grp_cnt[k]; i++) begin
          a = 12'(grp_base[k]) + 12'(4 * i);
          d = (8'h11 * 8'(p + 1)) ^ 8'(i);
          apb(1'b1, a, {24'hFFFFFF, d}, rd, er);
          check(32'(er), 32'h0);
          if (!g[k]) model_mem[a[7:2]] = d;
        end
      for (int k = 0; k < 3; k++)
        for (int i = 0; i < grp_cnt[k]; i++)
          rchk(12'(grp_base[k]) + 12'(4 * i), 32'(model_mem[grp_base[k][7:2] + i]));
      check(32'(clock_select), 32'(model_mem[CLOCK_SELECT_OFS[7:2]]));
      check(32'(irq_mask), 32'(model_mem[IRQ_MASK_OFS[7:2]]));
    end
    apb(1'b1, 12'(ACCESS_GUARD_CONTROL_OFS), 32'h0, rd, er);
    $display("test_guard done");
  endtask

  // Reset in mid-run clears every guard bit and reopens all groups
  task test_rereset;
    apb(1'b1, 12'(ACCESS_GUARD_CONTROL_OFS), 32'h7, rd, er);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'(ACCESS_GUARD_CONTROL_OFS), 32'h0);
    check(32'(guard_state), 32'h0);
    rchk(12'(MAIN_CLOCK_DIVIDER_OFS), 32'(MAIN_CLOCK_DIVIDER_RESET));
    apb(1'b1, 12'(CLOCK_SELECT_OFS), 32'h3C, rd, er);
    rchk(12'(CLOCK_SELECT_OFS), 32'h3C);
    apb(1'b1, 12'(IRQ_MASK_OFS), 32'h5A, rd, er);
    rchk(12'(IRQ_MASK_OFS), 32'h5A);
    apb(1'b1, 12'(PULLUP_ENABLE_OFS), 32'h96, rd, er);
    rchk(12'(PULLUP_ENABLE_OFS), 32'h96);
    $display("test_rereset done");
  endtask

  // Pin0 output-only, pin1 input-only, pins 2 and 3 open drain
  task test_pads;
    apb(1'b1, 12'(PORT_DIRECTION_OFS), 32'h00, rd, er);
    apb(1'b1, 12'(PORT_OUTPUT_LATCH_OFS), 32'hA5, rd, er);
    apb(1'b1, 12'(OUTPUT_DRIVE_MODE_OFS), 32'h0C, rd, er);
    repeat (3) @(posedge pclk);
    check(32'(pad_oe), 32'hF9);
    check(32'(pad_out & pad_oe), 32'hA1);
    apb(1'b1, 12'(PORT_DIRECTION_OFS), 32'hFF, rd, er);
    repeat (3) @(posedge pclk);
    check(32'(pad_oe), 32'h01);
    check(32'(pad_out & pad_oe), 32'h01);
    pad_in <= 8'hC3;
    repeat (2) @(posedge pclk);
    rchk(12'(PORT_PIN_LEVEL_OFS), 32'hC3);
    $display("test_pads done");
  endtask

  task test_unmapped;
    apb(1'b0, 12'h3FC, 32'h0, rd, er);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    $display("test_unmapped done");
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pad_in  = 8'h5A;
    err_total = 0;
    n_tests   = 0;
    for (int j = 0; j < 64; j++) model_mem[j] = GENERIC_RESET;
    model_mem[PORT_DIRECTION_OFS[7:2]]     = PORT_DIRECTION_RESET;
    model_mem[IRQ_MASK_OFS[7:2]]           = IRQ_MASK_RESET;
    model_mem[IRQ_PRIORITY_OFS[7:2]]       = IRQ_PRIORITY_RESET;
    model_mem[MAIN_CLOCK_DIVIDER_OFS[7:2]] = MAIN_CLOCK_DIVIDER_RESET;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_guard();
    test_rereset();
    test_pads();
    test_unmapped();
    finish_test();
  end
endmodule
